// [rtl/pdhs_pkg.sv]
// Package: constants and carrier types of the host-bus slave port
// Notes on behaviour
// - Slave runs at standard and fast rates on open-drain clock and data.
// - Data falling while clock high is a start; begin address byte.
// - First byte after start is address, MSB first, last bit direction.
// - Matching address byte is acknowledged by pulling data low.
// - One data bit moves per clock pulse.
// - Data changing while clock high is start or stop, never data.
// - Data rising while clock high is a stop; transaction ends.
// - Any number of bytes; each eight-bit byte has one acknowledge bit.
// - Transmitter releases data before ack; acknowledger holds low.
// - In a write, the device acknowledges every received byte.
// - After a read not-acknowledge, device releases the data line.
// - Device may hold clock low around a byte until ready.
// - After boot each port answers its own strap-selected address.
// - In boot loader state only the port A address is acknowledged; a CFG_ADDRESSED port still acks both of its addresses.
// - Second slave port takes addresses from application configuration.
// - A sub-address byte selects the command item that follows.
package pdhs_pkg;
	localparam logic [3:0] PDHS_ADDR_PREFIX = 4'h4;
	localparam int PDHS_ADDR_PREFIX_MSB = 7;
	localparam int PDHS_ADDR_PORT_BIT = 3;
	localparam int PDHS_ADDR_INDEX_LSB = 1;
	localparam int PDHS_BYTE_BITS = 8;
	localparam int PDHS_FILTER_LEN = 3;
	localparam logic [1:0] PDHS_INDEX_RESET = 2'h0;
	// Stretch release time before SCL is let go (ns) and in cycles
	localparam int PDHS_CLK_NS = 10;
	localparam int PDHS_SETUP_NS = 250;
	localparam int PDHS_SETUP_CYC = (PDHS_SETUP_NS + PDHS_CLK_NS - 1) /
		PDHS_CLK_NS;

	typedef enum logic [2:0] {
		PDHS_IDLE = 3'b000,
		PDHS_ADDR = 3'b001,
		PDHS_AACK = 3'b011,
		PDHS_RX = 3'b010,
		PDHS_TX = 3'b110,
		PDHS_TACK = 3'b111,
		PDHS_IGNORE = 3'b101
	} pdhs_state_t;

	// Received byte passed to the command layer
	typedef struct packed {
		logic port_b;
		logic first;
		logic [7:0] data;
	} pdhs_word_t;
endpackage : pdhs_pkg

// [rtl/pdhs_buf2.sv]
// Two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module pdhs_buf2
	import pdhs_pkg::*;
#(
	parameter int WIDTH = 10
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [2];
	logic wr_ptr;
	logic rd_ptr;
	logic [1:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != 2'h2);
	assign out_valid = (count != 2'h0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mem[0] <= '0;
			mem[1] <= '0;
		end else if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= 1'b0;
			rd_ptr <= 1'b0;
			count <= 2'h0;
		end else begin
			if (push)
				wr_ptr <= ~wr_ptr;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end
endmodule : pdhs_buf2
`default_nettype wire

// [rtl/pdhs_slave.sv]
// Host-bus I2C slave port with strap-selected per-port addresses
`timescale 1ns/1ps
`default_nettype none
module pdhs_slave
	import pdhs_pkg::*;
#(
	parameter int FILTER_LEN = PDHS_FILTER_LEN,
	// Set for the second slave port, whose two addresses come from the
	// loaded application configuration instead of the straps
	parameter bit CFG_ADDRESSED = 1'b0,
	parameter logic [6:0] CFG_ADDR_A = 7'h00,
	parameter logic [6:0] CFG_ADDR_B = 7'h01
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Host bus pins, open drain
	input wire logic host_port_clock_pin_in,
	output logic host_port_clock_pin_out,
	output logic host_port_clock_pin_oe_n,
	input wire logic host_port_data_pin_in,
	output logic host_port_data_pin_out,
	output logic host_port_data_pin_oe_n,
	// Mode and address selection
	input wire logic boot_loader_state,
	input wire logic [1:0] strap_index,
	// Received bytes toward the command layer
	output logic rx_valid,
	input wire logic rx_ready,
	output pdhs_word_t rx_word,
	// Bytes to send for reads
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	// Status
	output logic busy,
	output logic stop_seen
);
	// ------------------------------------------------------------
	// Line synchronisers and de-glitch filters
	// ------------------------------------------------------------
	logic [1:0] scl_sync;
	logic [1:0] sda_sync;
	logic [FILTER_LEN-1:0] scl_hist;
	logic [FILTER_LEN-1:0] sda_hist;
	logic scl;
	logic sda;
	logic scl_d;
	logic sda_d;
	// Pins pass two flops before anything else reads them

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_sync <= 2'h3;
			sda_sync <= 2'h3;
		end else begin
			scl_sync <= {scl_sync[0], host_port_clock_pin_in};
			sda_sync <= {sda_sync[0], host_port_data_pin_in};
		end
	end

	// Only a level stable for the whole window moves the filtered line
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_hist <= '1;
			sda_hist <= '1;
			scl <= 1'b1;
			sda <= 1'b1;
		end else begin
			scl_hist <= {scl_hist[FILTER_LEN-2:0], scl_sync[1]};
			sda_hist <= {sda_hist[FILTER_LEN-2:0], sda_sync[1]};
			if (&scl_hist)
				scl <= 1'b1;
			else if (~|scl_hist)
				scl <= 1'b0;
			if (&sda_hist)
				sda <= 1'b1;
			else if (~|sda_hist)
				sda <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	// ------------------------------------------------------------
	// Bus conditions
	// ------------------------------------------------------------
	logic start_det;
	logic stop_det;
	logic scl_rise;
	logic scl_fall;
	// Both lines pass the same delay, so their order is kept

	assign start_det = scl && scl_d && sda_d && !sda;
	assign stop_det = scl && scl_d && !sda_d && sda;
	// Sample data only on clock edges, so changes during high are control
	assign scl_rise = scl && !scl_d;
	assign scl_fall = !scl && scl_d;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic [7:0] shreg;
	logic addr_match;
	logic addr_port_b;
	logic strap_match;
	logic cfg_match_a;
	logic cfg_match_b;

	// Strap decode: fixed prefix, port bit and the strap-selected index
	assign strap_match =
		(shreg[PDHS_ADDR_PREFIX_MSB -: 4] == PDHS_ADDR_PREFIX) &&
		(shreg[PDHS_ADDR_INDEX_LSB +: 2] == strap_index);
	assign cfg_match_a = (shreg[7:1] == CFG_ADDR_A);
	assign cfg_match_b = (shreg[7:1] == CFG_ADDR_B);

	always_comb begin
		if (CFG_ADDRESSED) begin
			addr_port_b = cfg_match_b;
			addr_match = cfg_match_a || cfg_match_b;
		end else begin
			addr_port_b = shreg[PDHS_ADDR_PORT_BIT];
			addr_match = strap_match;
			// Port B only exists once the application has started
			if (addr_port_b && boot_loader_state)
				addr_match = 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Bit engine
	// ------------------------------------------------------------
	pdhs_state_t state;
	pdhs_state_t next_state;
	logic [3:0] bit_cnt;
	logic read_dir;
	logic port_b;
	logic first_byte;
	logic master_nack;
	logic sda_low;
	logic push_pending;
	logic buf_in_ready;

	// Byte boundary: eighth bit sampled on a rising clock edge
	logic byte_done;
	assign byte_done = scl_rise && (bit_cnt == 4'(PDHS_BYTE_BITS - 1));

	always_comb begin
		next_state = state;
		if (stop_det)
			next_state = PDHS_IDLE;
		else if (start_det)
			next_state = PDHS_ADDR;
		else begin
			case (state)
				PDHS_ADDR: begin
					if (scl_fall && bit_cnt == 4'(PDHS_BYTE_BITS))
						next_state = addr_match ? PDHS_AACK
							: PDHS_IGNORE;
				end
				PDHS_AACK: begin
					if (scl_fall)
						next_state = read_dir ? PDHS_TX : PDHS_RX;
				end
				PDHS_RX: begin
					if (scl_fall && bit_cnt == 4'(PDHS_BYTE_BITS))
						next_state = PDHS_AACK;
				end
				PDHS_TX: begin
					if (scl_fall && bit_cnt == 4'(PDHS_BYTE_BITS))
						next_state = PDHS_TACK;
				end
				PDHS_TACK: begin
					if (scl_fall)
						next_state = master_nack ? PDHS_IGNORE
							: PDHS_TX;
				end
				default: next_state = state;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			state <= PDHS_IDLE;
		else
			state <= next_state;
	end

	// Bit counter and shift register
	// Send bits shift on the fall, so the next one is set while SCL is low
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			bit_cnt <= 4'h0;
			shreg <= 8'h00;
		end else if (start_det || (scl_fall &&
				bit_cnt == 4'(PDHS_BYTE_BITS))) begin
			bit_cnt <= 4'h0;
			if (state == PDHS_AACK && read_dir && scl_fall)
				shreg <= tx_data;
			else if (state == PDHS_TACK && scl_fall)
				shreg <= tx_data;
		end else if (scl_rise && (state == PDHS_ADDR ||
				state == PDHS_RX || state == PDHS_TX)) begin
			bit_cnt <= bit_cnt + 4'h1;
			if (state != PDHS_TX)
				shreg <= {shreg[6:0], sda};
		end else if (scl_fall && state == PDHS_TX && bit_cnt != 4'h0) begin
			shreg <= {shreg[6:0], 1'b0};
		end else if (scl_fall && (state == PDHS_AACK ||
				state == PDHS_TACK)) begin
			if (next_state == PDHS_TX)
				shreg <= tx_data;
		end
	end

	// Transaction attributes
	// Direction and port are fixed by the address byte alone
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			read_dir <= 1'b0;
			port_b <= 1'b0;
			first_byte <= 1'b0;
			master_nack <= 1'b0;
		end else begin
			if (state == PDHS_ADDR && scl_fall &&
					bit_cnt == 4'(PDHS_BYTE_BITS)) begin
				read_dir <= shreg[0];
				port_b <= addr_port_b;
				first_byte <= 1'b1;
			end else if (state == PDHS_RX && scl_fall &&
					bit_cnt == 4'(PDHS_BYTE_BITS)) begin
				first_byte <= 1'b0;
			end
			if (state == PDHS_TACK && scl_rise)
				master_nack <= sda;
		end
	end

	// ------------------------------------------------------------
	// Receive path into the buffer
	// ------------------------------------------------------------
	pdhs_word_t push_word;
	// A word the full buffer cannot take waits here; the ack slot is
	// stretched meanwhile, so no later byte can overwrite it

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			push_pending <= 1'b0;
			push_word <= '0;
		end else if (state == PDHS_RX && byte_done) begin
			push_pending <= 1'b1;
			// First byte after the address is the sub-address item
			push_word <= '{port_b: port_b, first: first_byte,
				data: {shreg[6:0], sda}};
		end else if (buf_in_ready) begin
			push_pending <= 1'b0;
		end
	end

	pdhs_buf2 #(
		.WIDTH($bits(pdhs_word_t))
	) u_buf (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.in_valid(push_pending),
		.in_ready(buf_in_ready),
		.in_data(push_word),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_word)
	);

	// ------------------------------------------------------------
	// Clock stretching
	// ------------------------------------------------------------
	logic [7:0] setup_cnt;
	logic stall;
	logic stretch;
	// Stretch only once the line is already low, never cutting a high

	// Hold SCL low in a write ack slot while a byte cannot be taken, or before the first read bit while none is given
	assign stall = (state == PDHS_AACK && !read_dir && push_pending &&
		!buf_in_ready) || (state == PDHS_TX && bit_cnt == 4'h0 &&
		!tx_valid);

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			stretch <= 1'b0;
			setup_cnt <= 8'h00;
		end else if (stall && !scl) begin
			stretch <= 1'b1;
			setup_cnt <= 8'(PDHS_SETUP_CYC);
		end else if (setup_cnt != 8'h00) begin
			// Keep data settled before the master sees SCL again
			setup_cnt <= setup_cnt - 8'h01;
		end else begin
			stretch <= 1'b0;
		end
	end

	// The read byte is handed over on the fall that leaves an ack slot,
	// so the sender sees one load pulse per byte
	assign tx_ready = (state == PDHS_AACK || state == PDHS_TACK) &&
		scl_fall && next_state == PDHS_TX;

	// ------------------------------------------------------------
	// Pin drivers, open drain: enable low means drive low
	// ------------------------------------------------------------
	logic next_sda_low;

	// The eighth bit must stand through its whole high phase: letting go
	// early would show the master a stop
	always_comb begin
		next_sda_low = 1'b0;
		if (next_state == PDHS_AACK)
			next_sda_low = 1'b1;
		else if (next_state == PDHS_TX && state != PDHS_TX)
			next_sda_low = !tx_data[7];
		else if (next_state == PDHS_TX)
			next_sda_low = !shreg[7];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			sda_low <= 1'b0;
		else
			sda_low <= next_sda_low;
	end

	assign host_port_data_pin_out = 1'b0;
	assign host_port_data_pin_oe_n = !sda_low;
	assign host_port_clock_pin_out = 1'b0;
	assign host_port_clock_pin_oe_n = !stretch;
	assign busy = (state != PDHS_IDLE);
	assign stop_seen = stop_det;
endmodule : pdhs_slave
`default_nettype wire

// [tb/pdhs_slave_asserts.sv]
// Checker of the host-bus slave port behaviour at its pins and byte streams
`timescale 1ns/1ps
`default_nettype none
module pdhs_slave_asserts
	import pdhs_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// Host bus pins
	input wire logic host_port_clock_pin_in,
	input wire logic host_port_clock_pin_out,
	input wire logic host_port_clock_pin_oe_n,
	input wire logic host_port_data_pin_in,
	input wire logic host_port_data_pin_out,
	input wire logic host_port_data_pin_oe_n,
	// Mode and address
	input wire logic boot_loader_state,
	input wire logic [1:0] strap_index,
	// Byte streams
	input wire logic rx_valid,
	input wire logic rx_ready,
	input wire pdhs_word_t rx_word,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] tx_data,
	// Status
	input wire logic busy,
	input wire logic stop_seen
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);
	sequence start_s;
		host_port_clock_pin_in && $fell(host_port_data_pin_in);
	endsequence
	sequence stop_s;
		busy && host_port_clock_pin_in && $rose(host_port_data_pin_in);
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) !rstn |->
		host_port_data_pin_oe_n && host_port_clock_pin_oe_n && !busy)
		else $error("pins or busy active in reset");
	chk_drive_zero: assert property (!host_port_data_pin_oe_n |->
		!host_port_data_pin_out) else $error("data pin drives high");
	chk_start_busy: assert property (start_s |-> ##[1:12] busy)
		else $error("start not followed by busy");
	chk_stop_pulse: assert property (stop_s |-> ##[1:12] stop_seen)
		else $error("stop not reported");
	chk_stop_idle: assert property (stop_seen |-> ##[0:2] !busy)
		else $error("busy stays after stop");
	chk_idle_free: assert property (!busy |->
		host_port_data_pin_oe_n && host_port_clock_pin_oe_n)
		else $error("line held while idle");
	chk_sda_steady: assert property (host_port_clock_pin_in &&
		$past(host_port_clock_pin_in) |-> $stable(host_port_data_pin_oe_n))
		else $error("data changed while clock high");
	chk_stretch_low: assert property ($fell(host_port_clock_pin_oe_n)
		|-> !$past(host_port_clock_pin_in)) else $error("clock yanked low");
	chk_rx_hold: assert property (rx_valid && !rx_ready |=>
		rx_valid && $stable(rx_word)) else $error("stalled word lost");
	chk_tx_pulse: assert property (tx_ready |=> !tx_ready)
		else $error("load pulse too long");
endmodule : pdhs_slave_asserts
bind pdhs_slave pdhs_slave_asserts u_pdhs_slave_asserts (.*);
`default_nettype wire

// [tb/pdhs_master_model.sv]
// Behavioural bus master on the open-drain host-bus pins
`timescale 1ns/1ps
`default_nettype none
module pdhs_master_model #(
	// 4 x 65 cycles a bit keeps the clock under 400 kHz
	parameter int QTR = 65
) (
	// Clock
	input wire logic sys_clk,
	// Wire levels and pull-downs
	input wire logic scl,
	input wire logic sda,
	output logic scl_low,
	output logic sda_low,
	// Set when a stretch outlasts the limit
	output logic hung
);
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
		hung = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : wt
	// Release the clock and wait until the wire really rises
	task automatic hi();
		int n;
		n = 0;
		scl_low = 1'b0;
		while (!scl && n < 20000) begin
			@(negedge sys_clk);
			n++;
		end
		if (!scl)
			hung = 1'b1;
		wt(2 * QTR);
	endtask : hi
	// Data moves only while the clock is low, with hold after the fall
	task automatic bit_io(input logic b, output logic r);
		wt(QTR);
		sda_low = !b;
		wt(QTR);
		hi();
		r = sda;
		scl_low = 1'b1;
	endtask : bit_io
	task automatic byte_io(input logic [7:0] d, input logic m,
		output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(m, a);
	endtask : byte_io
	task automatic start();
		wt(QTR);
		sda_low = 1'b0;
		hi();
		sda_low = 1'b1;
		wt(2 * QTR);
		scl_low = 1'b1;
	endtask : start
	task automatic stop();
		wt(QTR);
		sda_low = 1'b1;
		wt(QTR);
		hi();
		sda_low = 1'b0;
		wt(4 * QTR);
	endtask : stop
endmodule : pdhs_master_model
`default_nettype wire

// [tb/tb_top.sv]
// Self-checking testbench of the host-bus slave port
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import pdhs_pkg::*;
	typedef struct packed {
		logic boot;
		logic [1:0] strap;
		logic [7:0] addr;
		logic ack;
	} pdhs_row_t;
	logic sys_clk, rstn, c_out, c_oe_n, d_out, d_oe_n, scl_w, sda_w;
	logic m_scl, m_sda, hung, boot, rx_ready, rx_valid, tx_valid, tx_ready;
	logic busy, stop_seen, a, stretched;
	logic [1:0] strap;
	logic [7:0] q, d;
	pdhs_word_t rx_word;
	pdhs_word_t rxq[$];
	logic [7:0] txl[4] = '{8'h5a, 8'ha5, 8'h00, 8'h00};
	logic [1:0] ti = 2'h0;
	int err_total, tests_run;
	pdhs_row_t rows[7] = '{'{1'b0, 2'h0, 8'h40, 1'b1},
		'{1'b0, 2'h3, 8'h4e, 1'b1}, '{1'b1, 2'h1, 8'h42, 1'b1},
		'{1'b1, 2'h1, 8'h4a, 1'b0}, '{1'b0, 2'h2, 8'h40, 1'b0},
		'{1'b0, 2'h1, 8'h52, 1'b0}, '{1'b0, 2'h2, 8'h4c, 1'b1}};
	// Pull-ups win unless someone pulls the wire low
	assign scl_w = !(m_scl || (!c_oe_n && !c_out));
	assign sda_w = !(m_sda || (!d_oe_n && !d_out));
	pdhs_slave u_pdhs_slave (.sys_clk(sys_clk), .rstn(rstn),
		.host_port_clock_pin_in(scl_w), .host_port_clock_pin_out(c_out),
		.host_port_clock_pin_oe_n(c_oe_n), .host_port_data_pin_in(sda_w),
		.host_port_data_pin_out(d_out), .host_port_data_pin_oe_n(d_oe_n),
		.boot_loader_state(boot), .strap_index(strap),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rx_word),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(txl[ti]),
		.busy(busy), .stop_seen(stop_seen));
	pdhs_master_model u_pdhs_master_model (.sys_clk(sys_clk), .scl(scl_w),
		.sda(sda_w), .scl_low(m_scl), .sda_low(m_sda), .hung(hung));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (rx_valid && rx_ready)
			rxq.push_back(rx_word);
		if (tx_ready)
			ti <= ti + 2'h1;
		if (!c_oe_n)
			stretched <= 1'b1;
	end
	task automatic chk(input string nm, input logic [9:0] e,
		input logic [9:0] s);
		tests_run++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, e, s);
		end
	endtask : chk
	task automatic summarize();
		$display("mismatches %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (90000) @(posedge sys_clk);
		err_total++;
		summarize();
	end
	initial begin
		rstn = 1'b0;
		boot = 1'b0;
		strap = 2'h0;
		rx_ready = 1'b1;
		tx_valid = 1'b0;
		stretched = 1'b0;
		repeat (10) @(negedge sys_clk);
		chk("reset", 10'h3, {c_oe_n, d_oe_n});
		chk("reset busy", 10'h0, {busy, rx_valid});
		rstn = 1'b1;
		tx_valid = 1'b1;
		for (int i = 0; i < 7; i++) begin
			boot = rows[i].boot;
			strap = rows[i].strap;
			d = 8'(8'h30 + i);
			u_pdhs_master_model.start();
			u_pdhs_master_model.byte_io(rows[i].addr, 1'b1, q, a);
			chk("addr ack", 10'(!rows[i].ack), 10'(a));
			u_pdhs_master_model.byte_io(d, 1'b1, q, a);
			chk("data ack", 10'(!rows[i].ack), 10'(a));
			u_pdhs_master_model.stop();
			chk("rx count", 10'(rows[i].ack), 10'(rxq.size()));
			if (rxq.size() > 0)
				chk("rx word", {rows[i].addr[3], 1'b1, d}, rxq.pop_front());
		end
		boot = 1'b0;
		strap = 2'h0;
		rx_ready = 1'b0;
		u_pdhs_master_model.start();
		u_pdhs_master_model.byte_io(8'h40, 1'b1, q, a);
		fork
			for (int i = 1; i < 5; i++) begin
				u_pdhs_master_model.byte_io(8'(i * 17), 1'b1, q, a);
				chk("burst ack", 10'h0, 10'(a));
			end
			begin
				repeat (8000) @(negedge sys_clk);
				rx_ready = 1'b1;
			end
		join
		u_pdhs_master_model.stop();
		chk("stretch", 10'h1, 10'(stretched));
		chk("burst count", 10'h4, 10'(rxq.size()));
		for (int i = 1; i < 5; i++)
			chk("burst word", {2'(i == 1), 8'(i * 17)}, rxq.pop_front());
		u_pdhs_master_model.start();
		chk("start busy", 10'h1, 10'(busy));
		rstn = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("mid reset", 10'h6, {busy, c_oe_n, d_oe_n, rx_valid});
		rstn = 1'b1;
		u_pdhs_master_model.stop();
		u_pdhs_master_model.start();
		u_pdhs_master_model.byte_io(8'h41, 1'b1, q, a);
		chk("read ack", 10'h0, 10'(a));
		u_pdhs_master_model.byte_io(8'hff, 1'b0, q, a);
		chk("read one", 10'h5a, 10'(q));
		u_pdhs_master_model.byte_io(8'hff, 1'b1, q, a);
		chk("read two", 10'ha5, 10'(q));
		chk("released", 10'h1, 10'(d_oe_n));
		u_pdhs_master_model.stop();
		chk("idle", 10'h0, {busy, hung});
		summarize();
	end
endmodule : tb_top
`default_nettype wire
